/* File: dprp_top.v */
/*
 * Reference profile register bank of the second digital loop: the tail of
 * the reference_input_c profile and the whole reference_input_d profile,
 * on an APB slave, plus the profile applied to the loop.
 * Assumes an APB3 master on pclk and a loop controller that reports which
 * reference it is locked to; the other reference_input_c fields arrive as
 * plain inputs from the neighbouring bank.
 */
`include "dprp_regs.vh"

module dprp_top #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Loop lock state
  input wire loop_locked,
  input wire lock_on_ref_d,
  // reference_input_c fields held elsewhere
  input wire [15:0] ref_c_loop_bandwidth_setting,
  input wire ref_c_high_phase_margin,
  input wire [16:0] ref_c_integer_feedback_count,
  // reference_input_d selection controls
  output wire [1:0] ref_d_selection_rank,
  output wire ref_d_lock_permit,
  // Profile applied to the loop
  output wire applied_valid,
  output wire [15:0] applied_loop_bandwidth_setting,
  output wire applied_high_phase_margin,
  output wire [17:0] applied_integer_divide,
  output wire [22:0] applied_fraction_numerator,
  output wire [22:0] applied_fraction_modulus,
  output wire applied_fraction_ok
);

  localparam [8*`DPRP_NUM_SLOTS-1:0] RST_VEC = `DPRP_RESET_VEC;
  localparam [8*`DPRP_NUM_SLOTS-1:0] MASK_VEC = `DPRP_WMASK_VEC;
  localparam [13:0] IDX_BASE = `DPRP_IDX_BASE;
  localparam [13:0] IDX_LAST = `DPRP_IDX_D_MOD_HI;
  localparam [13:0] IDX_STATUS = `DPRP_IDX_STATUS;

  // Bus slave state
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg pready_q;
  reg pslverr_q;
  reg pslverr_d;

  // Applied profile state
  reg applied_valid_q;
  reg [15:0] app_bw_q;
  reg app_high_pm_q;
  reg [17:0] app_int_q;
  reg [22:0] app_num_q;
  reg [22:0] app_mod_q;
  reg app_frac_ok_q;
  reg [1:0] rank_q;
  reg permit_q;

  // Decode
  wire [13:0] idx;
  wire [13:0] slot_full;
  wire [`DPRP_SLOT_W-1:0] slot;
  wire aligned;
  wire hit_profile;
  wire hit_status;
  wire setup_phase;
  wire wr_commit;
  wire [8*`DPRP_NUM_SLOTS-1:0] all_bytes;
  wire [`DPRP_NUM_SLOTS-1:0] slot_wr;
  wire [7:0] status_byte;

  // Field views of storage
  wire [22:0] c_num;
  wire [22:0] c_mod;
  wire [22:0] d_num;
  wire [22:0] d_mod;
  wire [15:0] d_bw;
  wire [16:0] d_int_m1;
  wire d_high_pm;
  wire [1:0] d_rank;
  wire d_permit;

  // Selected profile before registering
  reg [15:0] sel_bw;
  reg sel_high_pm;
  reg [16:0] sel_int_m1;
  reg [22:0] sel_num;
  reg [22:0] sel_mod;

  assign idx = paddr[ADDR_W-1:2];
  assign slot_full = idx - IDX_BASE;
  assign slot = slot_full[`DPRP_SLOT_W-1:0];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_profile = aligned && (idx >= IDX_BASE) && (idx <= IDX_LAST);
  assign hit_status = aligned && (idx == IDX_STATUS);
  assign setup_phase = psel && !penable;
  // Writes land only at the completing edge of a mapped, error-free access
  assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q && hit_profile;

  // Profile byte storage, one flop byte per slot
  genvar g;
  generate
    for (g = 0; g < `DPRP_NUM_SLOTS; g = g + 1) begin : gen_slot
      assign slot_wr[g] = wr_commit && (slot == g);
      dprp_byte_reg #(
        .RESET_VAL(RST_VEC[8*g+7:8*g]),
        .WR_MASK(MASK_VEC[8*g+7:8*g])
      ) u_byte (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(slot_wr[g]),
        .wr_data(pwdata[7:0]),
        .q(all_bytes[8*g+7:8*g])
      );
    end
  endgenerate

  // Fraction fields, low byte first, top byte bit 7 reserved
  assign c_num = {all_bytes[8*`DPRP_SLOT_C_NUM_HI+`DPRP_FRAC_TOP_MSB:8*`DPRP_SLOT_C_NUM_HI],
                  all_bytes[8*`DPRP_SLOT_C_NUM_MID+7:8*`DPRP_SLOT_C_NUM_MID],
                  all_bytes[8*`DPRP_SLOT_C_NUM_LO+7:8*`DPRP_SLOT_C_NUM_LO]};
  assign c_mod = {all_bytes[8*`DPRP_SLOT_C_MOD_HI+`DPRP_FRAC_TOP_MSB:8*`DPRP_SLOT_C_MOD_HI],
                  all_bytes[8*`DPRP_SLOT_C_MOD_MID+7:8*`DPRP_SLOT_C_MOD_MID],
                  all_bytes[8*`DPRP_SLOT_C_MOD_LO+7:8*`DPRP_SLOT_C_MOD_LO]};
  assign d_num = {all_bytes[8*`DPRP_SLOT_D_NUM_HI+`DPRP_FRAC_TOP_MSB:8*`DPRP_SLOT_D_NUM_HI],
                  all_bytes[8*`DPRP_SLOT_D_NUM_MID+7:8*`DPRP_SLOT_D_NUM_MID],
                  all_bytes[8*`DPRP_SLOT_D_NUM_LO+7:8*`DPRP_SLOT_D_NUM_LO]};
  assign d_mod = {all_bytes[8*`DPRP_SLOT_D_MOD_HI+`DPRP_FRAC_TOP_MSB:8*`DPRP_SLOT_D_MOD_HI],
                  all_bytes[8*`DPRP_SLOT_D_MOD_MID+7:8*`DPRP_SLOT_D_MOD_MID],
                  all_bytes[8*`DPRP_SLOT_D_MOD_LO+7:8*`DPRP_SLOT_D_MOD_LO]};

  // Bandwidth in 0.1 Hz steps, low byte first
  assign d_bw = {all_bytes[8*`DPRP_SLOT_D_BW_HI+7:8*`DPRP_SLOT_D_BW_HI],
                 all_bytes[8*`DPRP_SLOT_D_BW_LO+7:8*`DPRP_SLOT_D_BW_LO]};

  // Integer divider held as divide value minus one
  assign d_int_m1 = {all_bytes[8*`DPRP_SLOT_D_INT_HI+`DPRP_INT_TOP_BIT],
                     all_bytes[8*`DPRP_SLOT_D_INT_MID+7:8*`DPRP_SLOT_D_INT_MID],
                     all_bytes[8*`DPRP_SLOT_D_INT_LO+7:8*`DPRP_SLOT_D_INT_LO]};

  assign d_high_pm = all_bytes[8*`DPRP_SLOT_D_FILT+`DPRP_HIGH_PM_BIT];
  assign d_rank = all_bytes[8*`DPRP_SLOT_D_PRIO+`DPRP_RANK_MSB:8*`DPRP_SLOT_D_PRIO+`DPRP_RANK_LSB];
  assign d_permit = all_bytes[8*`DPRP_SLOT_D_PRIO+`DPRP_PERMIT_BIT];

  assign status_byte = {5'h00,
                        permit_q,
                        app_frac_ok_q,
                        applied_valid_q && lock_on_ref_d};

  // Read mux and error decode, evaluated during the setup cycle
  always @* begin
    prdata_d = 32'h00000000;
    pslverr_d = 1'b0;
    if (hit_profile) begin
      prdata_d = {24'h000000, all_bytes[8*slot +: 8]};
    end else if (hit_status) begin
      prdata_d = {24'h000000, status_byte};
      pslverr_d = pwrite;
    end else begin
      pslverr_d = 1'b1;
    end
  end

  // Fixed one-cycle access: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_phase;
      if (setup_phase) begin
        pslverr_q <= pslverr_d;
        prdata_q <= pwrite ? 32'h00000000 : prdata_d;
      end else if (!psel) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Pick the locked reference's own profile
  always @* begin
    if (lock_on_ref_d) begin
      sel_bw = d_bw;
      sel_high_pm = d_high_pm;
      sel_int_m1 = d_int_m1;
      sel_num = d_num;
      sel_mod = d_mod;
    end else begin
      sel_bw = ref_c_loop_bandwidth_setting;
      sel_high_pm = ref_c_high_phase_margin;
      sel_int_m1 = ref_c_integer_feedback_count;
      sel_num = c_num;
      sel_mod = c_mod;
    end
  end

  // Registered profile; divide is stored value plus one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_valid_q <= 1'b0;
      app_bw_q <= 16'h0000;
      app_high_pm_q <= 1'b0;
      app_int_q <= 18'h00000;
      app_num_q <= 23'h000000;
      app_mod_q <= 23'h000000;
      app_frac_ok_q <= 1'b0;
      rank_q <= 2'h0;
      permit_q <= 1'b0;
    end else begin
      applied_valid_q <= loop_locked;
      app_bw_q <= sel_bw;
      app_high_pm_q <= sel_high_pm;
      app_int_q <= {1'b0, sel_int_m1} + 18'h00001;
      app_num_q <= sel_num;
      app_mod_q <= sel_mod;
      // Zero modulus or improper fraction is flagged, not corrected
      app_frac_ok_q <= (sel_mod != 23'h000000) && (sel_num < sel_mod);
      rank_q <= d_rank;
      permit_q <= d_permit;
    end
  end

  // Bus outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Selection controls for the reference arbiter
  assign ref_d_selection_rank = rank_q;
  assign ref_d_lock_permit = permit_q;

  // Applied profile to the loop
  assign applied_valid = applied_valid_q;
  assign applied_loop_bandwidth_setting = app_bw_q;
  assign applied_high_phase_margin = app_high_pm_q;
  assign applied_integer_divide = app_int_q;
  assign applied_fraction_numerator = app_num_q;
  assign applied_fraction_modulus = app_mod_q;
  assign applied_fraction_ok = app_frac_ok_q;

endmodule

/* File: dprp_regs.vh */
/*
 * Register map constants for the second digital loop reference profiles
 * (reference_input_c tail and reference_input_d).
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef DPRP_REGS_VH
`define DPRP_REGS_VH

// Register indices; byte address is four times the index
`define DPRP_IDX_C_NUM_LO 14'h0547
`define DPRP_IDX_C_NUM_MID 14'h0548
`define DPRP_IDX_C_NUM_HI 14'h0549
`define DPRP_IDX_C_MOD_LO 14'h054a
`define DPRP_IDX_C_MOD_MID 14'h054b
`define DPRP_IDX_C_MOD_HI 14'h054c
`define DPRP_IDX_D_PRIO 14'h054d
`define DPRP_IDX_D_BW_LO 14'h054e
`define DPRP_IDX_D_BW_HI 14'h054f
`define DPRP_IDX_D_FILT 14'h0550
`define DPRP_IDX_D_INT_LO 14'h0551
`define DPRP_IDX_D_INT_MID 14'h0552
`define DPRP_IDX_D_INT_HI 14'h0553
`define DPRP_IDX_D_NUM_LO 14'h0554
`define DPRP_IDX_D_NUM_MID 14'h0555
`define DPRP_IDX_D_NUM_HI 14'h0556
`define DPRP_IDX_D_MOD_LO 14'h0557
`define DPRP_IDX_D_MOD_MID 14'h0558
`define DPRP_IDX_D_MOD_HI 14'h0559
`define DPRP_IDX_STATUS 14'h0600

// Profile storage is one contiguous run of byte slots
`define DPRP_IDX_BASE 14'h0547
`define DPRP_NUM_SLOTS 19
`define DPRP_SLOT_W 5

// Slot numbers (index minus base)
`define DPRP_SLOT_C_NUM_LO 0
`define DPRP_SLOT_C_NUM_MID 1
`define DPRP_SLOT_C_NUM_HI 2
`define DPRP_SLOT_C_MOD_LO 3
`define DPRP_SLOT_C_MOD_MID 4
`define DPRP_SLOT_C_MOD_HI 5
`define DPRP_SLOT_D_PRIO 6
`define DPRP_SLOT_D_BW_LO 7
`define DPRP_SLOT_D_BW_HI 8
`define DPRP_SLOT_D_FILT 9
`define DPRP_SLOT_D_INT_LO 10
`define DPRP_SLOT_D_INT_MID 11
`define DPRP_SLOT_D_INT_HI 12
`define DPRP_SLOT_D_NUM_LO 13
`define DPRP_SLOT_D_NUM_MID 14
`define DPRP_SLOT_D_NUM_HI 15
`define DPRP_SLOT_D_MOD_LO 16
`define DPRP_SLOT_D_MOD_MID 17
`define DPRP_SLOT_D_MOD_HI 18

// Reset values, slot 18 in the top byte
`define DPRP_RESET_VEC {8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h04, 8'h00, 8'h07, 8'hcb, \
  8'h00, 8'h01, 8'hf4, 8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h04}

// Writable bits per slot; reserved bits stay zero
`define DPRP_WMASK_VEC {8'h7f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, \
  8'h02, 8'hff, 8'hff, 8'h07, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff}

// Field positions
`define DPRP_RANK_MSB 2
`define DPRP_RANK_LSB 1
`define DPRP_PERMIT_BIT 0
`define DPRP_HIGH_PM_BIT 1
`define DPRP_INT_TOP_BIT 0
`define DPRP_FRAC_TOP_MSB 6

// Status byte fields
`define DPRP_STAT_ON_D_BIT 0
`define DPRP_STAT_FRAC_OK_BIT 1
`define DPRP_STAT_D_USABLE_BIT 2

`endif

/* File: dprp_byte_reg.v */
/*
 * One profile byte with its reset value and writable-bit mask.
 * Assumes a single-cycle write enable from the bus slave.
 */
module dprp_byte_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_data,
  // Stored value
  output wire [7:0] q
);

  reg [7:0] byte_q;

  assign q = byte_q;

  // Reserved bits are forced to zero on every write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_q <= RESET_VAL;
    end else if (wr_en) begin
      byte_q <= wr_data & WR_MASK;
    end
  end

endmodule

/* File: dprp_properties.sv */
/*
 * Checker for the reference profile bank: APB timing and applied profile.
 * Assumes binding onto dprp_top; sees its ports only.
 */
module dprp_props #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire [ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // Loop side
  input wire lock_on_ref_d,
  input wire [15:0] ref_c_loop_bandwidth_setting,
  input wire ref_c_high_phase_margin,
  input wire [16:0] ref_c_integer_feedback_count,
  input wire [1:0] ref_d_selection_rank,
  input wire ref_d_lock_permit,
  input wire [15:0] applied_loop_bandwidth_setting,
  input wire applied_high_phase_margin,
  input wire [17:0] applied_integer_divide,
  input wire [22:0] applied_fraction_numerator,
  input wire [22:0] applied_fraction_modulus,
  input wire applied_fraction_ok
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Priority byte write that lands
  wire prio_wr = psel && penable && pready && pwrite && !pslverr && paddr == 16'h1534;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held");
  property p_misal; psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr; endproperty
  a_misal: assert property (p_misal) else $error("misaligned accepted");
  property p_permit; prio_wr |=> ##1 ref_d_lock_permit == $past(pwdata[0], 2); endproperty
  a_permit: assert property (p_permit) else $error("permit wrong");
  property p_rank; prio_wr |=> ##1 ref_d_selection_rank == $past(pwdata[2:1], 2); endproperty
  a_rank: assert property (p_rank) else $error("rank wrong");
  property p_bw; !lock_on_ref_d |=> applied_loop_bandwidth_setting ==
    $past(ref_c_loop_bandwidth_setting); endproperty
  a_bw: assert property (p_bw) else $error("bandwidth not from C");
  property p_hpm; !lock_on_ref_d |=> applied_high_phase_margin ==
    $past(ref_c_high_phase_margin); endproperty
  a_hpm: assert property (p_hpm) else $error("margin not from C");
  property p_int; !lock_on_ref_d |=> applied_integer_divide ==
    {1'b0, $past(ref_c_integer_feedback_count)} + 18'h1; endproperty
  a_int: assert property (p_int) else $error("divide not plus one");
  property p_ok; applied_fraction_ok == (applied_fraction_modulus != 23'h0 &&
    applied_fraction_numerator < applied_fraction_modulus); endproperty
  a_ok: assert property (p_ok) else $error("fraction flag wrong");
endmodule

bind dprp_top dprp_props #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .lock_on_ref_d(lock_on_ref_d),
  .ref_c_loop_bandwidth_setting(ref_c_loop_bandwidth_setting),
  .ref_c_high_phase_margin(ref_c_high_phase_margin),
  .ref_c_integer_feedback_count(ref_c_integer_feedback_count),
  .ref_d_selection_rank(ref_d_selection_rank),
  .ref_d_lock_permit(ref_d_lock_permit),
  .applied_loop_bandwidth_setting(applied_loop_bandwidth_setting),
  .applied_high_phase_margin(applied_high_phase_margin),
  .applied_integer_divide(applied_integer_divide),
  .applied_fraction_numerator(applied_fraction_numerator),
  .applied_fraction_modulus(applied_fraction_modulus),
  .applied_fraction_ok(applied_fraction_ok)
);

/* File: test_dpll_ref_profile_regs.sv */
/*
 * Self-checking bench for the reference profile bank.
 * Assumes dprp_top with zero-wait APB and one-cycle applied outputs.
 */
module test_dpll_ref_profile_regs;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [13:0] i; logic [7:0] d; logic [7:0] e;} dprp_row_t;
  logic pclk, presetn, psel, penable, pwrite, loop_locked, lock_on_ref_d, er;
  logic ref_c_high_phase_margin, pready, pslverr, ref_d_lock_permit, applied_valid;
  logic applied_high_phase_margin, applied_fraction_ok;
  logic [1:0] ref_d_selection_rank;
  logic [15:0] paddr, ref_c_loop_bandwidth_setting, applied_loop_bandwidth_setting;
  logic [16:0] ref_c_integer_feedback_count;
  logic [17:0] applied_integer_divide;
  logic [22:0] applied_fraction_numerator, applied_fraction_modulus;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] rv [19] = '{8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01, 8'hf4, 8'h01,
    8'h00, 8'hcb, 8'h07, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
  logic [7:0] wm [19] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'h07, 8'hff, 8'hff,
    8'h02, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h7f};
  // Index, data written, data read back
  dprp_row_t rows [20] = '{'{14'h54d, 8'h02, 8'h02}, '{14'h54d, 8'h04, 8'h04},
    '{14'h54d, 8'h06, 8'h06}, '{14'h54d, 8'hf8, 8'h00}, '{14'h54d, 8'h07, 8'h07},
    // Bandwidth 466 Hz: over 50 Hz, under 2 kHz, detector above 9.4 kHz
    '{14'h54e, 8'h34, 8'h34}, '{14'h54f, 8'h12, 8'h12}, '{14'h550, 8'hff, 8'h02},
    '{14'h550, 8'h01, 8'h00}, '{14'h550, 8'h02, 8'h02}, '{14'h551, 8'h0a, 8'h0a},
    '{14'h553, 8'hff, 8'h01}, '{14'h554, 8'h03, 8'h03}, '{14'h556, 8'h80, 8'h00},
    '{14'h557, 8'h10, 8'h10}, '{14'h559, 8'hff, 8'h7f}, '{14'h547, 8'haa, 8'haa},
    '{14'h549, 8'hff, 8'h7f}, '{14'h54a, 8'h55, 8'h55}, '{14'h54c, 8'h80, 8'h00}};

  dprp_top i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .loop_locked(loop_locked),
    .lock_on_ref_d(lock_on_ref_d),
    .ref_c_loop_bandwidth_setting(ref_c_loop_bandwidth_setting),
    .ref_c_high_phase_margin(ref_c_high_phase_margin),
    .ref_c_integer_feedback_count(ref_c_integer_feedback_count),
    .ref_d_selection_rank(ref_d_selection_rank),
    .ref_d_lock_permit(ref_d_lock_permit),
    .applied_valid(applied_valid),
    .applied_loop_bandwidth_setting(applied_loop_bandwidth_setting),
    .applied_high_phase_margin(applied_high_phase_margin),
    .applied_integer_divide(applied_integer_divide),
    .applied_fraction_numerator(applied_fraction_numerator),
    .applied_fraction_modulus(applied_fraction_modulus),
    .applied_fraction_ok(applied_fraction_ok)
  );

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Leaves the bus held so the next call can follow back to back
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      chk("pready", pready, 1);
      wrap_up();
    end
  endtask

  task automatic idle();
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic chk_defaults();
    for (int k = 0; k < 19; k++) begin
      apb(0, 16'h151c + 16'(4 * k), 0);
      chk("reset value", rd, rv[k]);
    end
    idle();
    $display("done: reset values");
  endtask

  initial begin
    {psel, penable, pwrite, loop_locked, lock_on_ref_d, ref_c_high_phase_margin} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 0;
    ref_c_loop_bandwidth_setting = 16'h0abc;
    ref_c_integer_feedback_count = 17'h1ffff;
    repeat (6) @(posedge pclk);
    chk("permit in reset", ref_d_lock_permit, 0);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk("rank", ref_d_selection_rank, 0);
    chk("permit", ref_d_lock_permit, 1);
    chk("valid off", applied_valid, 0);
    chk_defaults();
    foreach (rows[k]) begin
      apb(1, {rows[k].i, 2'b00}, rows[k].d);
      apb(0, {rows[k].i, 2'b00}, 0);
      chk("readback", rd, rows[k].e);
    end
    idle();
    $display("done: readback rows");
    lock_on_ref_d <= 1;
    loop_locked <= 1;
    repeat (2) @(posedge pclk);
    chk("bw d", applied_loop_bandwidth_setting, 16'h1234);
    chk("margin d", applied_high_phase_margin, 1);
    chk("int d", applied_integer_divide, 18'h1070b);
    chk("num d", applied_fraction_numerator, 23'd3);
    chk("mod d", applied_fraction_modulus, 23'h7f0010);
    chk("ok d", applied_fraction_ok, 1);
    chk("rank d", ref_d_selection_rank, 2'b11);
    chk("valid", applied_valid, 1);
    apb(0, 16'h1800, 0);
    chk("status d", rd, 32'h7);
    idle();
    $display("done: reference d applied");
    lock_on_ref_d <= 0;
    ref_c_high_phase_margin <= 1;
    repeat (2) @(posedge pclk);
    chk("bw c", applied_loop_bandwidth_setting, 16'h0abc);
    chk("margin c", applied_high_phase_margin, 1);
    chk("int c", applied_integer_divide, 18'h20000);
    chk("num c", applied_fraction_numerator, 23'h7f00aa);
    chk("mod c", applied_fraction_modulus, 23'h55);
    chk("ok c", applied_fraction_ok, 0);
    $display("done: reference c applied");
    apb(0, 16'h1568, 0);
    chk("unmapped data", rd, 0);
    chk("unmapped err", er, 1);
    apb(1, 16'h1535, 0);
    chk("misaligned err", er, 1);
    apb(1, 16'h1800, 0);
    chk("status write err", er, 1);
    apb(0, 16'h1800, 0);
    chk("status", rd, 32'h4);
    apb(0, 16'h1534, 0);
    chk("priority kept", rd, 32'h7);
    for (int k = 0; k < 19; k++) begin
      apb(1, 16'h151c + 16'(4 * k), 32'hff);
      apb(0, 16'h151c + 16'(4 * k), 0);
      chk("writable bits", rd, wm[k]);
    end
    idle();
    $display("done: refusals and masks");
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk_defaults();
    wrap_up();
  end
endmodule
